// ==== rtl/porseq_detect.v ====
`timescale 1ns/1ps
`include "porseq_consts.vh"

// ==========================================================
// per-supply level detector: good only after a stable run of samples
module porseq_detect (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // raw comparator level
  input wire i_level,
  // filtered good flag
  output reg o_good
);

  reg [`PORSEQ_STAB_W-1:0] stab_ff;

  // glitch filter: a single bad sample drops good at once
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      stab_ff <= {`PORSEQ_STAB_W{1'b0}};
      o_good <= 1'b0;
    end else if (!i_level) begin
      stab_ff <= {`PORSEQ_STAB_W{1'b0}};
      o_good <= 1'b0;
    end else if (stab_ff != `PORSEQ_STAB_MAX) begin
      stab_ff <= stab_ff + {{(`PORSEQ_STAB_W-1){1'b0}}, 1'b1};
      o_good <= 1'b0;
    end else begin
      o_good <= 1'b1;
    end
  end

endmodule // porseq_detect

// ==== rtl/porseq_top.v ====
`timescale 1ns/1ps
`include "porseq_consts.vh"

module porseq_top #(
  parameter [`PORSEQ_CNT_W-1:0] RAMP_CYC = `PORSEQ_RAMP_CYC,
  parameter [`PORSEQ_CNT_W-1:0] DLY_STD_CYC = `PORSEQ_DLY_STD_CYC,
  parameter [`PORSEQ_CNT_W-1:0] DLY_FAST_CYC = `PORSEQ_DLY_FAST_CYC
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // supply comparator levels, one per monitored rail
  input wire [`PORSEQ_NSUP-1:0] i_supply_ok,
  // delay select: 1 fast, 0 standard
  input wire i_fast_por,
  // reset and configuration control
  output reg o_proc_reset_n,
  output reg o_config_start,
  output reg o_ramp_fail,
  // i/o state and registered per-supply good flags
  output reg o_io_oe_n,
  output reg o_io_pullup_en,
  output reg [`PORSEQ_NSUP-1:0] o_supply_good
);

  localparam [1:0] ST_WAIT = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;
  localparam [1:0] ST_FAIL = 2'h3;

  wire [`PORSEQ_NSUP-1:0] good;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`PORSEQ_CNT_W-1:0] ramp_ff;
  reg [`PORSEQ_CNT_W-1:0] nxt_ramp;
  reg [`PORSEQ_CNT_W-1:0] dly_ff;
  reg [`PORSEQ_CNT_W-1:0] nxt_dly;
  reg [`PORSEQ_CNT_W-1:0] dly_target;
  wire proc_ok;
  wire all_ok;
  wire ramp_done;
  wire dly_done;
  reg trip_ff;
  reg nxt_trip;
  reg nxt_proc_reset_n;
  reg nxt_config_start;
  reg nxt_ramp_fail;
  reg nxt_io_oe_n;
  reg nxt_io_pullup_en;

  // ==========================================================
  // independent detectors
  genvar gi;
  generate
    for (gi = 0; gi < `PORSEQ_NSUP; gi = gi + 1) begin : g_det
      porseq_detect u_det (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_supply_ok[gi]),
        .o_good(good[gi])
      );
    end
  endgenerate

  // fuse rail left out of processor gating
  assign proc_ok = &(good | ~`PORSEQ_PROC_MASK);
  assign all_ok = &good;

  // ==========================================================
  // delay selection and counter limits
  always @* begin
    dly_target = i_fast_por ? DLY_FAST_CYC : DLY_STD_CYC;
  end

  // limit minus one, so the state flop lands on the exact count
  assign ramp_done = (ramp_ff >= (RAMP_CYC - `PORSEQ_CNT_ONE));
  assign dly_done = (dly_ff >= (dly_target - `PORSEQ_CNT_ONE));

  // ==========================================================
  // sequencer next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT: begin
        if (all_ok) begin
          nxt_state = ST_DELAY;
        end else if (!trip_ff && ramp_done) begin
          nxt_state = ST_FAIL;
        end else begin
          nxt_state = ST_WAIT;
        end
      end
      ST_DELAY: begin
        if (!all_ok) begin
          nxt_state = ST_WAIT;
        end else if (dly_done) begin
          nxt_state = ST_DONE;
        end else begin
          nxt_state = ST_DELAY;
        end
      end
      ST_DONE: begin
        // a brown-out drops back into reset
        if (!all_ok) begin
          nxt_state = ST_WAIT;
        end else begin
          nxt_state = ST_DONE;
        end
      end
      ST_FAIL: begin
        // latched until power cycle (reset)
        nxt_state = ST_FAIL;
      end
      default: begin
        nxt_state = ST_WAIT;
      end
    endcase
  end

  // ==========================================================
  // ramp window: open from reset until the first full trip
  always @* begin
    nxt_trip = trip_ff;
    if ((state_ff == ST_WAIT) && all_ok) begin
      nxt_trip = 1'h1;
    end
  end

  // later brown-outs restart the delay but never count as a ramp miss
  always @* begin
    nxt_ramp = ramp_ff;
    if ((state_ff == ST_WAIT) && !trip_ff && !all_ok && !ramp_done) begin
      nxt_ramp = ramp_ff + `PORSEQ_CNT_ONE;
    end
  end

  // ==========================================================
  // por delay counter, cleared whenever a rail is lost
  always @* begin
    nxt_dly = `PORSEQ_CNT_ZERO;
    if ((state_ff == ST_DELAY) && all_ok && !dly_done) begin
      nxt_dly = dly_ff + `PORSEQ_CNT_ONE;
    end
  end

  // ==========================================================
  // sequencer registers
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= ST_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      trip_ff <= `PORSEQ_RST_TRIP;
    end else begin
      trip_ff <= nxt_trip;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ramp_ff <= `PORSEQ_CNT_ZERO;
    end else begin
      ramp_ff <= nxt_ramp;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      dly_ff <= `PORSEQ_CNT_ZERO;
    end else begin
      dly_ff <= nxt_dly;
    end
  end

  // ==========================================================
  // output decode, taken from the next state so pins come off flops
  always @* begin
    nxt_proc_reset_n = proc_ok && (nxt_state != ST_FAIL);
    nxt_config_start = (nxt_state == ST_DONE);
    nxt_ramp_fail = (nxt_state == ST_FAIL);
    // pins stay released with pull-up until configuration may run
    nxt_io_oe_n = (nxt_state != ST_DONE);
    nxt_io_pullup_en = (nxt_state != ST_DONE);
  end

  // ==========================================================
  // registered outputs
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_proc_reset_n <= `PORSEQ_RST_PROC_N;
    end else begin
      o_proc_reset_n <= nxt_proc_reset_n;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_config_start <= `PORSEQ_RST_START;
    end else begin
      o_config_start <= nxt_config_start;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ramp_fail <= `PORSEQ_RST_FAIL;
    end else begin
      o_ramp_fail <= nxt_ramp_fail;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_io_oe_n <= `PORSEQ_RST_OE_N;
    end else begin
      o_io_oe_n <= nxt_io_oe_n;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_io_pullup_en <= `PORSEQ_RST_PULLUP;
    end else begin
      o_io_pullup_en <= nxt_io_pullup_en;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_supply_good <= `PORSEQ_RST_GOOD;
    end else begin
      o_supply_good <= good;
    end
  end

endmodule // porseq_top

// ==== shared/porseq_consts.vh ====
// Function
// - hold the device in reset until every monitored supply is in range.
// - one detector per supply; start configuration only when all detectors report good.
// - if supplies miss the ramp limit, keep I/O and programming tri-stated.
// - after all supplies pass, wait a configurable delay, then configure.
// - delay counts from combined detector trip to final reset release; the code ends it at o_config_start and does not delay o_proc_reset_n.
// - monitor core, cram, aux, adc, mgmt io, battery, ps core, fuse supplies.
// - fuse supply does not hold processor power-up but blocks configuration.
// - during power-up keep I/O tri-stated with weak pull-up enabled.
`ifndef PORSEQ_CONSTS_VH
`define PORSEQ_CONSTS_VH

// ==========================================================
// supply vector layout
`define PORSEQ_NSUP 8
`define PORSEQ_SUP_CORE 0
`define PORSEQ_SUP_CRAM 1
`define PORSEQ_SUP_AUX 2
`define PORSEQ_SUP_ADC 3
`define PORSEQ_SUP_MIO 4
`define PORSEQ_SUP_BAT 5
`define PORSEQ_SUP_PSC 6
`define PORSEQ_SUP_FUSE 7
// supplies that gate processor power-up (fuse excluded)
`define PORSEQ_PROC_MASK 8'h7F

// ==========================================================
// timing
`define PORSEQ_CLK_MHZ 250
`define PORSEQ_RAMP_MS 10
`define PORSEQ_RAMP_CYC (`PORSEQ_RAMP_MS * `PORSEQ_CLK_MHZ * 1000)
`define PORSEQ_DLY_STD_MS 9
`define PORSEQ_DLY_FAST_MS 4
`define PORSEQ_DLY_STD_CYC (`PORSEQ_DLY_STD_MS * `PORSEQ_CLK_MHZ * 1000)
`define PORSEQ_DLY_FAST_CYC (`PORSEQ_DLY_FAST_MS * `PORSEQ_CLK_MHZ * 1000)
`define PORSEQ_CNT_W 32
`define PORSEQ_STAB_W 2
`define PORSEQ_STAB_MAX 2'h3
`define PORSEQ_CNT_ZERO 32'h0
`define PORSEQ_CNT_ONE 32'h1

// ==========================================================
// reset levels of the sequencer flops
`define PORSEQ_RST_TRIP 1'h0
`define PORSEQ_RST_PROC_N 1'h0
`define PORSEQ_RST_START 1'h0
`define PORSEQ_RST_FAIL 1'h0
`define PORSEQ_RST_OE_N 1'h1
`define PORSEQ_RST_PULLUP 1'h1
`define PORSEQ_RST_GOOD 8'h00

`endif

// ==== tb/porseq_chk_asserts.sv ====
`timescale 1ns/1ps
// ==========================================================
// port checker
module porseq_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire [7:0] o_supply_good,
  input wire o_proc_reset_n,
  input wire o_config_start,
  input wire o_ramp_fail,
  input wire o_io_oe_n,
  input wire o_io_pullup_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start; $rose(o_config_start); endsequence
  reg seen_start = 1'b0;
  always @(posedge i_clk)
    seen_start <= !i_rst_n ? 1'b0 : (seen_start | o_config_start);
  a_no_late_fail: assert property (seen_start |-> !o_ramp_fail)
    else $error("ramp fail after release");
  a_oe_follows: assert property (o_io_oe_n == !o_config_start)
    else $error("oe not tied to start");
  a_pullup_oe: assert property (o_io_pullup_en == o_io_oe_n)
    else $error("pullup not with tristate");
  a_fail_held: assert property (o_ramp_fail |->
    !o_proc_reset_n && o_io_oe_n && !o_config_start) else $error("fail");
  a_fail_sticky: assert property (o_ramp_fail |=> o_ramp_fail)
    else $error("fail flag lost");
  a_start_all: assert property (s_start |-> o_supply_good == 8'hFF)
    else $error("start without all good");
  a_delay_min: assert property (s_start |->
    $past(o_supply_good, 8) == 8'hFF) else $error("delay too short");
  a_drop_stop: assert property (o_supply_good != 8'hFF |-> ##2
    !o_config_start) else $error("start kept after drop");
  a_proc_up: assert property (
    o_supply_good[6:0] == 7'h7F && !o_ramp_fail |-> ##[0:2] o_proc_reset_n)
    else $error("proc held");
endmodule // porseq_chk
bind porseq_top porseq_chk porseq_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .o_supply_good(o_supply_good), .o_proc_reset_n(o_proc_reset_n),
  .o_config_start(o_config_start), .o_ramp_fail(o_ramp_fail),
  .o_io_oe_n(o_io_oe_n), .o_io_pullup_en(o_io_pullup_en));

// ==== tb/porseq_supply_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// rails rise one at a time, lowest first; a dropped rail falls at once
module porseq_supply_model (
  input wire i_clk,
  input wire [7:0] i_want,
  input wire i_slow,
  output reg [7:0] o_level
);
  reg ph = 1'b0;
  wire [7:0] miss = i_want & ~o_level;
  initial o_level = 8'h0;
  always @(posedge i_clk) begin
    ph <= ~ph;
    o_level <= (o_level & i_want) | ((ph | !i_slow) ? miss & -miss : 8'h0);
  end
endmodule // porseq_supply_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  reg i_clk = 0, i_rst_n = 0, i_fast_por = 0, slow = 0;
  reg [7:0] want = 8'h0;
  wire [7:0] sup, good;
  wire prst_n, cfg, fail, oe_n, pu;
  int err_count = 0, num_checks = 0, n;
  always #2 i_clk = ~i_clk;
  porseq_supply_model porseq_supply_model_i (.i_clk(i_clk), .i_want(want),
    .i_slow(slow), .o_level(sup));
  porseq_top #(.RAMP_CYC(32'h32), .DLY_STD_CYC(32'h14),
    .DLY_FAST_CYC(32'h8)) porseq_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_supply_ok(sup), .i_fast_por(i_fast_por), .o_proc_reset_n(prst_n),
    .o_config_start(cfg), .o_ramp_fail(fail), .o_io_oe_n(oe_n),
    .o_io_pullup_en(pu), .o_supply_good(good));
  task automatic rst(input [7:0] w);
    @(posedge i_clk) i_rst_n <= 1'b0;
    want <= w;
    repeat (8) @(posedge i_clk);
    #1;
    `CHK({prst_n, cfg, fail, oe_n, pu, good}, 13'h300)
    @(posedge i_clk) i_rst_n <= 1'b1;
  endtask
  task automatic t_delay(input fast, input int drop, input int exp);
    rst(8'hFF);
    i_fast_por <= fast;
    n = 0;
    for (int k = 0; k < 300 && cfg !== 1'b1; k++) begin
      @(posedge i_clk) want <= (k == drop) ? 8'hFE : 8'hFF;
      #1;
      n = (good === 8'hFF) ? n + 1 : 0;
    end
    `CHK(n, exp)
    `CHK({prst_n, oe_n, pu}, 3'h4)
    $display("test delay done");
  endtask
  task automatic t_rails;
    for (int b = 0; b < 8; b++) begin
      @(posedge i_clk) want <= ~(8'h1 << b);
      repeat (6) @(posedge i_clk);
      #1;
      `CHK({cfg, oe_n, prst_n}, {2'h1, b == 7})
      @(posedge i_clk) want <= 8'hFF;
      slow <= b[0];
      repeat (40) @(posedge i_clk);
      #1;
      `CHK(cfg, 1'b1)
    end
    $display("test rails done");
  endtask
  task automatic t_ramp;
    rst(8'h7F);
    repeat (60) @(posedge i_clk);
    #1;
    `CHK({fail, prst_n, oe_n, pu}, 4'hB)
    @(posedge i_clk) want <= 8'hFF;
    repeat (60) @(posedge i_clk);
    #1;
    `CHK({fail, cfg}, 2'h2)
    $display("test ramp done");
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_delay(1'b0, -1, 21);
    t_delay(1'b1, 8, 9);
    t_rails;
    t_ramp;
    results;
  end
  initial begin
    #20000;
    err_count++;
    results;
  end
endmodule // tb_top
